// *** core/serial_channel_register_bank.sv ***
// register bank of a dual-channel serial controller behind a byte-wide host port
// assumes host strobes and line status arrive asynchronously; serialiser lives elsewhere
//
// What this block does
// - channel B offers three readable status registers, numbered zero to two; channel A only zero and one
// - status zero: break, underrun, cts, sync, carrier, tx empty, pending, rx available
// - status one: end of frame, crc, overrun, parity, residue code, all sent
// - channel B owns eight write registers and channel A seven, programmed independently
// - register zero: pointer in bits 2..0, command 5..3, crc reset 7..6
// - register one: wait/ready controls, receive interrupt mode, vector status, enables
// - one vector register serves both channels and exists only in channel B
// - with status-affects-vector set, acknowledged vector bits 3..1 carry the cause
// - cause substitution never changes the stored vector
// - register three holds receiver character size, hunt, crc, search and enable
// - register four holds clock rate, sync mode, stop bits and parity
// - register five holds transmitter controls; bit 2 picks the crc polynomial
// - register six holds sync pattern bits 7..0
// - register seven holds sync pattern bits 15..8
// - a host read returns a data byte or a status byte by address
// - a host write stores a data byte or a control byte by address
// - acknowledge and return-from-interrupt follow the daisy-chained peripheral sequence
// - priority chain out is formed from priority chain in and own activity
// - wait/ready acts as ready for dma, as wait for the processor
`timescale 1ns/1ns
module serial_channel_register_bank
   import serial_regs_pkg::*;
(
   input  wire logic                          clk,
   input  wire logic                          resetn,
   input  wire host_bus_t                     hostIn,
   input  wire line_status_t [NUM_CH-1:0]     lineIn,
   output logic [7:0]                         dataOut,
   output logic                               dataOe,
   output logic                               intOe,
   output logic                               priority_chain_out,
   output logic [NUM_CH-1:0]                  waitOe,
   output reg_bank_t                          cfgOut,
   output logic [NUM_CH-1:0][7:0]             txData,
   output logic [NUM_CH-1:0]                  txStrobe
);

   logic                   rstMeta;
   logic                   rstSync;
   state_t                 st_q;
   state_t                 st_d;
   logic                   curCh;
   logic                   rdAct;
   logic                   wrAct;
   logic                   ackAct;
   logic                   rdStart;
   logic                   wrStart;
   logic                   ackStart;
   logic [NUM_CH-1:0]      pendTx;
   logic [NUM_CH-1:0]      pendRx;
   logic [NUM_CH-1:0]      pendSpec;
   logic [NUM_CH-1:0]      pend;
   logic                   anyPend;
   logic                   winnerA;
   logic [2:0]             causeCode;
   logic [7:0]             storedVector;
   logic [7:0]             modVector;
   logic [7:0]             statusMain;
   logic [7:0]             statusSpecial;
   logic [7:0]             readback;

   // reset enters asynchronously, released through two flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta <= 1'h0;
         rstSync <= 1'h0;
      end else begin
         rstMeta <= 1'h1;
         rstSync <= rstMeta;
      end
   end

   assign curCh    = st_q.host.chanA;
   assign rdAct    = !st_q.host.ceN && !st_q.host.rdN && st_q.host.ackN;
   assign wrAct    = !st_q.host.ceN && !st_q.host.wrN;
   assign ackAct   = !st_q.host.ackN && !st_q.host.rdN;
   assign rdStart  = rdAct && !st_q.rdSeen;
   assign wrStart  = wrAct && !st_q.wrSeen;
   assign ackStart = ackAct && !st_q.ackSeen;

   // per-channel interrupt sources
   for (genvar c = 0; c < NUM_CH; c++) begin : g_pend
      logic rxIntOn;
      assign rxIntOn     = |st_q.wreg[c][REG_INT_WAIT][RXINT_MSB:RXINT_LSB];
      assign pendTx[c]   = st_q.wreg[c][REG_INT_WAIT][TXINT_BIT] && st_q.line[c].txEmpty;
      assign pendRx[c]   = rxIntOn && st_q.line[c].rxAvail;
      assign pendSpec[c] = rxIntOn && (st_q.line[c].endOfFrame || st_q.line[c].crcError
                                       || st_q.line[c].rxOverrun || st_q.line[c].parityError);
      assign pend[c]     = pendTx[c] || pendRx[c] || pendSpec[c];
   end

   assign anyPend      = |pend;
   assign winnerA      = pend[CH_A];
   assign storedVector = st_q.wreg[CH_B][REG_VECTOR];

   // channel A outranks B; within a channel special beats receive beats transmit
   always_comb begin
      logic [1:0] cause;
      cause = CAUSE_TX;
      if (pendSpec[winnerA]) begin
         cause = CAUSE_SPECIAL;
      end else if (pendRx[winnerA]) begin
         cause = CAUSE_RX;
      end
      causeCode = anyPend ? {winnerA, cause} : CAUSE_NONE;
   end

   // stored vector is only read here, never rewritten
   always_comb begin
      modVector = storedVector;
      if (st_q.wreg[CH_B][REG_INT_WAIT][SAV_BIT]) begin
         modVector[VEC_CODE_MSB:VEC_CODE_LSB] = causeCode;
      end
   end

   assign statusMain = {st_q.line[curCh].breakAbort, st_q.line[curCh].txUnderrun,
                        st_q.line[curCh].cts, st_q.line[curCh].syncHunt,
                        st_q.line[curCh].carrierDetect, st_q.line[curCh].txEmpty,
                        (curCh == CH_A) && anyPend, st_q.line[curCh].rxAvail};
   assign statusSpecial = {st_q.line[curCh].endOfFrame, st_q.line[curCh].crcError,
                           st_q.line[curCh].rxOverrun, st_q.line[curCh].parityError,
                           st_q.line[curCh].residue, st_q.line[curCh].allSent};

   always_comb begin
      case (st_q.ptr[curCh])
         PTR_STATUS:  readback = statusMain;
         PTR_SPECIAL: readback = statusSpecial;
         PTR_VECTOR:  readback = (curCh == CH_B) ? modVector : REG_RESET;
         default:     readback = REG_RESET;
      endcase
   end

   always_comb begin
      st_d          = st_q;
      // three-stage pin capture; a bit moves once stages two and three agree
      st_d.hs1      = hostIn;
      st_d.hs2      = st_q.hs1;
      st_d.hs3      = st_q.hs2;
      st_d.host     = host_bus_t'((st_q.hs2 & st_q.hs3) | (st_q.host & (st_q.hs2 | st_q.hs3)));
      st_d.ls1      = lineIn;
      st_d.ls2      = st_q.ls1;
      st_d.ls3      = st_q.ls2;
      st_d.line     = (st_q.ls2 & st_q.ls3) | (st_q.line & (st_q.ls2 | st_q.ls3));
      st_d.rdSeen   = rdAct;
      st_d.wrSeen   = wrAct;
      st_d.ackSeen  = ackAct;
      st_d.txStrobe = '0;
      if (!rdAct && !ackAct) begin
         st_d.dataOe = 1'h0;
      end
      if (wrStart) begin
         if (st_q.host.dataSel) begin
            st_d.txData[curCh]   = st_q.host.data;
            st_d.txStrobe[curCh] = 1'h1;
         end else if (st_q.ptr[curCh] == REG_PTR_CMD) begin
            st_d.wreg[curCh][REG_PTR_CMD] = st_q.host.data;
            st_d.ptr[curCh] = st_q.host.data[PTR_MSB:PTR_LSB];
            if (st_q.host.data[CMD_MSB:CMD_LSB] == CMD_CHAN_RESET) begin
               // vector is shared, so a channel reset keeps it
               for (int r = 1; r < REG_CNT; r++) begin
                  if (r != int'(REG_VECTOR)) begin
                     st_d.wreg[curCh][r] = REG_RESET;
                  end
               end
               st_d.ptr[curCh]       = REG_PTR_CMD;
               st_d.inService[curCh] = 1'h0;
            end
            if (st_q.host.data[CMD_MSB:CMD_LSB] == CMD_RET_INT) begin
               st_d.inService = '0;
            end
         end else begin
            // channel A has no vector register; such a write is dropped
            if (!(curCh == CH_A && st_q.ptr[curCh] == REG_VECTOR)) begin
               st_d.wreg[curCh][st_q.ptr[curCh]] = st_q.host.data;
            end
            st_d.ptr[curCh] = REG_PTR_CMD;
         end
      end
      if (rdStart) begin
         st_d.dataOe  = 1'h1;
         st_d.dataOut = st_q.host.dataSel ? st_q.line[curCh].rxData : readback;
         if (!st_q.host.dataSel) begin
            st_d.ptr[curCh] = REG_PTR_CMD;
         end
      end
      if (ackStart && st_q.host.chainIn && anyPend && !(|st_q.inService)) begin
         st_d.dataOut            = modVector;
         st_d.dataOe             = 1'h1;
         st_d.inService[winnerA] = 1'h1;
      end
      st_d.intOe    = st_q.host.chainIn && anyPend && !(|st_q.inService);
      st_d.chainOut = st_q.host.chainIn && !anyPend && !(|st_q.inService);
      for (int c = 0; c < NUM_CH; c++) begin
         logic onRx;
         logic charReady;
         logic waitHere;
         onRx      = st_q.wreg[c][REG_INT_WAIT][WAIT_RX_BIT];
         charReady = onRx ? st_q.line[c].rxAvail : st_q.line[c].txEmpty;
         waitHere  = (curCh == c[0]) && st_q.host.dataSel && (rdAct || wrAct) && !charReady;
         // ready mode pulls low for the dma, wait mode stretches a processor access
         st_d.waitOe[c] = st_q.wreg[c][REG_INT_WAIT][WAIT_EN_BIT]
                          && (st_q.wreg[c][REG_INT_WAIT][WAIT_FN_BIT] ? charReady
                                                                       : waitHere);
      end
   end

   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         st_q <= STATE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // serialiser outside this bank consumes the fields
   assign cfgOut             = st_q.wreg;
   assign dataOut            = st_q.dataOut;
   assign dataOe             = st_q.dataOe;
   assign intOe              = st_q.intOe;
   assign priority_chain_out = st_q.chainOut;
   assign waitOe             = st_q.waitOe;
   assign txData             = st_q.txData;
   assign txStrobe           = st_q.txStrobe;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync);

   ptr_return_a: assert property ((wrStart || rdStart) && !st_q.host.dataSel
      && st_q.ptr[curCh] != REG_PTR_CMD |=> st_q.ptr[$past(curCh)] == REG_PTR_CMD)
      else $error("pointer did not fall back to zero");

   ptr_load_a: assert property (wrStart && !st_q.host.dataSel
      && st_q.ptr[curCh] == REG_PTR_CMD && st_q.host.data[CMD_MSB:CMD_LSB] != CMD_CHAN_RESET
      |=> st_q.ptr[$past(curCh)] == $past(st_q.host.data[PTR_MSB:PTR_LSB]))
      else $error("pointer not loaded from command byte");

   vector_only_b_a: assert property (st_q.wreg[CH_A][REG_VECTOR] == REG_RESET)
      else $error("channel A holds a vector register");

   vector_kept_a: assert property (ackStart |=> $stable(st_q.wreg[CH_B][REG_VECTOR]))
      else $error("acknowledge changed stored vector");

   vector_cause_a: assert property (ackStart && st_q.host.chainIn && anyPend
      && !(|st_q.inService) && st_q.wreg[CH_B][REG_INT_WAIT][SAV_BIT]
      |=> dataOe && dataOut[7:4] == storedVector[7:4] && dataOut[0] == storedVector[0]
          && dataOut[3:1] == $past(causeCode))
      else $error("vector cause bits wrong");

   status_main_a: assert property (rdStart && !st_q.host.dataSel
      && st_q.ptr[curCh] == PTR_STATUS
      |=> dataOut[2] == $past(st_q.line[curCh].txEmpty)
          && dataOut[0] == $past(st_q.line[curCh].rxAvail) && dataOe)
      else $error("main status readback wrong");

   data_read_a: assert property (rdStart && st_q.host.dataSel
      |=> dataOe && dataOut == $past(st_q.line[curCh].rxData) ##1 (dataOe || !rdAct))
      else $error("data read not returned");

   data_write_a: assert property (wrStart && st_q.host.dataSel
      |=> txStrobe[$past(curCh)] && txData[$past(curCh)] == $past(st_q.host.data)
          ##1 txStrobe == '0)
      else $error("data write not a single strobe");

   chain_block_a: assert property ((|st_q.inService) |=> !priority_chain_out)
      else $error("chain passed while in service");

   ready_mode_a: assert property (st_q.wreg[CH_B][REG_INT_WAIT][WAIT_EN_BIT]
      && st_q.wreg[CH_B][REG_INT_WAIT][WAIT_FN_BIT]
      && st_q.wreg[CH_B][REG_INT_WAIT][WAIT_RX_BIT] && st_q.line[CH_B].rxAvail
      |=> waitOe[CH_B])
      else $error("ready not asserted");

endmodule // serial_channel_register_bank

// *** shared/serial_regs_pkg.sv ***
// constants, carriers and state layout of the dual-channel serial register bank
// assumes one 10 MHz clock and host pins that are asynchronous to it
package serial_regs_pkg;

   localparam int          NUM_CH         = 2;
   localparam int          REG_CNT        = 8;
   localparam logic        CH_B           = 1'h0;
   localparam logic        CH_A           = 1'h1;

   // write register indexes, selected by the pointer
   localparam logic [2:0]  REG_PTR_CMD    = 3'h0;
   localparam logic [2:0]  REG_INT_WAIT   = 3'h1;
   localparam logic [2:0]  REG_VECTOR     = 3'h2;
   localparam logic [2:0]  REG_RX_CTRL    = 3'h3;
   localparam logic [2:0]  REG_FORMAT     = 3'h4;
   localparam logic [2:0]  REG_TX_CTRL    = 3'h5;
   localparam logic [2:0]  REG_SYNC_LO    = 3'h6;
   localparam logic [2:0]  REG_SYNC_HI    = 3'h7;

   // read register indexes
   localparam logic [2:0]  PTR_STATUS     = 3'h0;
   localparam logic [2:0]  PTR_SPECIAL    = 3'h1;
   localparam logic [2:0]  PTR_VECTOR     = 3'h2;

   // pointer_and_command fields
   localparam int          PTR_LSB        = 0;
   localparam int          PTR_MSB        = 2;
   localparam int          CMD_LSB        = 3;
   localparam int          CMD_MSB        = 5;
   localparam logic [2:0]  CMD_CHAN_RESET = 3'h3;
   localparam logic [2:0]  CMD_RET_INT    = 3'h7;

   // interrupt_and_wait_control fields
   localparam int          WAIT_EN_BIT    = 7;
   localparam int          WAIT_FN_BIT    = 6;
   localparam int          WAIT_RX_BIT    = 5;
   localparam int          RXINT_MSB      = 4;
   localparam int          RXINT_LSB      = 3;
   localparam int          SAV_BIT        = 2;
   localparam int          TXINT_BIT      = 1;
   localparam int          EXTINT_BIT     = 0;

   // condition codes substituted into vector bits 3..1
   localparam int          VEC_CODE_LSB   = 1;
   localparam int          VEC_CODE_MSB   = 3;
   localparam logic [1:0]  CAUSE_TX       = 2'h0;
   localparam logic [1:0]  CAUSE_EXT      = 2'h1;
   localparam logic [1:0]  CAUSE_RX       = 2'h2;
   localparam logic [1:0]  CAUSE_SPECIAL  = 2'h3;
   localparam logic [2:0]  CAUSE_NONE     = 3'h3;

   localparam logic [7:0]  REG_RESET      = 8'h00;

   typedef struct packed {
      logic       ceN;
      logic       chanA;
      logic       dataSel;
      logic       rdN;
      logic       wrN;
      logic       ackN;
      logic       chainIn;
      logic [7:0] data;
   } host_bus_t;

   typedef struct packed {
      logic       breakAbort;
      logic       txUnderrun;
      logic       cts;
      logic       syncHunt;
      logic       carrierDetect;
      logic       txEmpty;
      logic       rxAvail;
      logic       endOfFrame;
      logic       crcError;
      logic       rxOverrun;
      logic       parityError;
      logic [2:0] residue;
      logic       allSent;
      logic [7:0] rxData;
   } line_status_t;

   typedef logic [NUM_CH-1:0][REG_CNT-1:0][7:0] reg_bank_t;

   typedef struct packed {
      host_bus_t                        hs1;
      host_bus_t                        hs2;
      host_bus_t                        hs3;
      host_bus_t                        host;
      line_status_t [NUM_CH-1:0]        ls1;
      line_status_t [NUM_CH-1:0]        ls2;
      line_status_t [NUM_CH-1:0]        ls3;
      line_status_t [NUM_CH-1:0]        line;
      reg_bank_t                        wreg;
      logic [NUM_CH-1:0][2:0]           ptr;
      logic [NUM_CH-1:0]                inService;
      logic                             rdSeen;
      logic                             wrSeen;
      logic                             ackSeen;
      logic [7:0]                       dataOut;
      logic                             dataOe;
      logic                             intOe;
      logic                             chainOut;
      logic [NUM_CH-1:0]                waitOe;
      logic [NUM_CH-1:0][7:0]           txData;
      logic [NUM_CH-1:0]                txStrobe;
   } state_t;

   localparam host_bus_t HOST_IDLE = '{ceN: 1'h1, chanA: 1'h0, dataSel: 1'h0, rdN: 1'h1,
                                       wrN: 1'h1, ackN: 1'h1, chainIn: 1'h0, data: 8'h00};

   localparam state_t STATE_RESET = '{hs1: HOST_IDLE, hs2: HOST_IDLE, hs3: HOST_IDLE,
                                      host: HOST_IDLE, default: '0};

endpackage

// *** tb/host_model.sv ***
// host processor model: byte read, write and acknowledge cycles on the host pins
// assumes a 10 MHz clock; pins change at the falling edge only
`timescale 1ns/1ns
module host_model
   import serial_regs_pkg::*;
(
   input  wire logic clk,
   output host_bus_t hostOut
);
   initial hostOut = HOST_IDLE;

   // strobe held 6 cycles: pins need 4 edges to settle, 2 cycles minimum level
   task automatic access(input logic chA, input logic ds, input logic isRd,
                         input logic isAck, input logic [7:0] d);
      host_bus_t b;
      b         = hostOut;
      b.chanA   = chA;
      b.dataSel = ds;
      b.data    = d;
      b.ceN     = isAck;
      b.rdN     = !(isRd || isAck);
      b.wrN     = isRd || isAck;
      b.ackN    = !isAck;
      @(negedge clk);
      hostOut   = b;
      repeat (6) @(negedge clk);
      b         = hostOut;
      b.ceN     = 1'h1;
      b.rdN     = 1'h1;
      b.wrN     = 1'h1;
      b.ackN    = 1'h1;
      // released bus must not keep the old byte
      b.data    = ~d;
      hostOut   = b;
      repeat (6) @(negedge clk);
   endtask

   task automatic write_reg(input logic chA, input logic [2:0] idx, input logic [7:0] v);
      access(chA, 1'h0, 1'h0, 1'h0, {5'h00, idx});
      access(chA, 1'h0, 1'h0, 1'h0, v);
   endtask

   // format register first, then the mode qualifiers
   task automatic init_channel(input logic chA, input logic [7:0] v [REG_CNT]);
      write_reg(chA, REG_FORMAT, v[4]);
      for (int r = 1; r < REG_CNT; r++) begin
         if (r != 4) begin
            write_reg(chA, r[2:0], v[r]);
         end
      end
   endtask

   task automatic set_chain(input logic v);
      @(negedge clk);
      hostOut.chainIn = v;
   endtask
endmodule // host_model

// *** tb/testbench.sv ***
// self-checking bench for the serial channel register bank
// assumes host_model drives every host pin; line status is randomised here
`timescale 1ns/1ns
module testbench;
   import serial_regs_pkg::*;
   logic                      clk;
   logic                      resetn;
   host_bus_t                 hostIn;
   line_status_t [NUM_CH-1:0] lineIn;
   logic [7:0]                dataOut;
   logic                      dataOe;
   logic                      intOe;
   logic                      chainOut;
   logic [NUM_CH-1:0]         waitOe;
   reg_bank_t                 cfgOut;
   logic [NUM_CH-1:0][7:0]    txData;
   logic [NUM_CH-1:0]         txStrobe;
   int                        failures;
   int                        check_count;
   int                        strobeCnt = 0;
   logic [7:0]                expQ[$];
   logic [7:0]                cfgVal [NUM_CH][REG_CNT];
   logic [7:0]                vec;
   logic [63:0]               rnd;
   logic                      oePrev;
   line_status_t              ls;

   host_model host_u (.clk(clk), .hostOut(hostIn));

   serial_channel_register_bank dut_u (
      .clk(clk), .resetn(resetn), .hostIn(hostIn), .lineIn(lineIn),
      .dataOut(dataOut), .dataOe(dataOe), .intOe(intOe),
      .priority_chain_out(chainOut), .waitOe(waitOe), .cfgOut(cfgOut),
      .txData(txData), .txStrobe(txStrobe));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // every rising drive of the data bus answers the oldest queued read
   initial oePrev = 1'h0;
   always @(negedge clk) begin
      if (dataOe === 1'h1 && oePrev !== 1'h1) begin
         if (expQ.size() == 0) begin
            check("unrequested drive", {7'h00, dataOe}, 8'h00);
         end else begin
            check("read byte", dataOut, expQ.pop_front());
         end
      end
      oePrev    = dataOe;
      strobeCnt = strobeCnt + $countones(txStrobe);
   end

   initial begin
      repeat (20000) @(posedge clk);
      check("timeout", 8'h01, 8'h00);
      end_sim();
   end

   initial begin
      resetn      = 1'h0;
      lineIn      = '0;
      failures    = 0;
      check_count = 0;
      void'($urandom(13735));
      repeat (20) @(negedge clk);
      resetn = 1'h1;
      repeat (4) @(negedge clk);
      for (int c = 0; c < NUM_CH; c++) begin
         for (int r = 0; r < REG_CNT; r++) begin
            check("cfg reset", cfgOut[c][r], REG_RESET);
         end
      end
      // channels get different random settings to expose crosstalk
      for (int c = 0; c < NUM_CH; c++) begin
         for (int r = 0; r < REG_CNT; r++) begin
            cfgVal[c][r] = 8'($urandom());
         end
         cfgVal[c][1] = (c == 1) ? 8'h00 : (cfgVal[c][1] & 8'hFB);
         host_u.init_channel(c[0], cfgVal[c]);
      end
      for (int c = 0; c < NUM_CH; c++) begin
         for (int r = 1; r < REG_CNT; r++) begin
            check("cfg reg", cfgOut[c][r],
                  (c == 1 && r == 2) ? REG_RESET
                  : cfgVal[c][r]);
         end
      end
      vec = cfgVal[0][2];
      // status reads with random line state
      rnd    = {$urandom(), $urandom()};
      lineIn = rnd[$bits(lineIn)-1:0];
      ls     = lineIn[CH_B];
      // pending bit only reported on channel A
      expQ.push_back({ls.breakAbort, ls.txUnderrun, ls.cts, ls.syncHunt,
                      ls.carrierDetect, ls.txEmpty, 1'h0, ls.rxAvail});
      host_u.access(CH_B, 1'h0, 1'h1, 1'h0, 8'h00);
      host_u.access(CH_B, 1'h0, 1'h0, 1'h0, {5'h00, PTR_SPECIAL});
      expQ.push_back({ls.endOfFrame, ls.crcError, ls.rxOverrun, ls.parityError,
                      ls.residue, ls.allSent});
      host_u.access(CH_B, 1'h0, 1'h1, 1'h0, 8'h00);
      // pointer has fallen back, so this is status zero again
      expQ.push_back({ls.breakAbort, ls.txUnderrun, ls.cts, ls.syncHunt,
                      ls.carrierDetect, ls.txEmpty, 1'h0, ls.rxAvail});
      host_u.access(CH_B, 1'h0, 1'h1, 1'h0, 8'h00);
      host_u.access(CH_B, 1'h0, 1'h0, 1'h0, {5'h00, PTR_VECTOR});
      expQ.push_back(vec);
      host_u.access(CH_B, 1'h0, 1'h1, 1'h0, 8'h00);
      host_u.access(CH_A, 1'h0, 1'h0, 1'h0, {5'h00, PTR_VECTOR});
      expQ.push_back(8'h00);
      host_u.access(CH_A, 1'h0, 1'h1, 1'h0, 8'h00);
      expQ.push_back(ls.rxData);
      host_u.access(CH_B, 1'h1, 1'h1, 1'h0, 8'h00);
      for (int c = 0; c < NUM_CH; c++) begin
         host_u.access(c[0], 1'h1, 1'h0, 1'h0, cfgVal[c][6] ^ 8'h5A);
         check("tx data", txData[c], cfgVal[c][6] ^ 8'h5A);
      end
      check("tx strobes", 8'(strobeCnt), 8'h02);
      // transmit interrupt on B with status-affects-vector set
      ls         = '0;
      ls.txEmpty = 1'h1;
      lineIn     = {line_status_t'('0), ls};
      host_u.write_reg(CH_B, REG_INT_WAIT, 8'h06);
      host_u.set_chain(1'h0);
      host_u.access(CH_B, 1'h0, 1'h0, 1'h1, 8'h00);
      host_u.set_chain(1'h1);
      repeat (6) @(negedge clk);
      check("int request", {7'h00, intOe}, 8'h01);
      expQ.push_back({vec[7:4], 1'h0, CAUSE_TX, vec[0]});
      host_u.access(CH_B, 1'h0, 1'h0, 1'h1, 8'h00);
      check("stored vector", cfgOut[CH_B][REG_VECTOR], vec);
      check("chain in service", {7'h00, chainOut}, 8'h00);
      lineIn[CH_B].txEmpty = 1'h0;
      host_u.access(CH_B, 1'h0, 1'h0, 1'h0, {2'h0, CMD_RET_INT, 3'h0});
      check("chain released", {7'h00, chainOut}, 8'h01);
      // ready mode on B follows receive character available
      host_u.write_reg(CH_B, REG_INT_WAIT, 8'hE0);
      check("ready idle", {6'h00, waitOe}, 8'h00);
      lineIn[CH_B].rxAvail = 1'h1;
      repeat (6) @(negedge clk);
      check("ready line", {6'h00, waitOe}, 8'h01);
      // channel reset clears B but keeps the shared vector and channel A
      host_u.access(CH_B, 1'h0, 1'h0, 1'h0, {2'h0, CMD_CHAN_RESET, 3'h0});
      check("reset clears", cfgOut[CH_B][REG_INT_WAIT], REG_RESET);
      check("reset keeps vector", cfgOut[CH_B][REG_VECTOR], vec);
      check("other channel", cfgOut[CH_A][REG_FORMAT], cfgVal[1][4]);
      check("reads answered", 8'(expQ.size()), 8'h00);
      end_sim();
   end
endmodule // testbench
